// *** shared/clock_stop_standby_map.svh ***
`ifndef CLOCK_STOP_STANDBY_MAP_SVH
`define CLOCK_STOP_STANDBY_MAP_SVH

// clock rate
`define CLK_MHZ            10
`define CLK_KHZ            10000

// standby enable noise filter: time in ns and cycles (least time, rounded up)
`define DEB_TIME_NS        187500
`define DEB_CYC            ((`DEB_TIME_NS * `CLK_MHZ + 999) / 1000)

// timer carry periods and wake delay after a stop, in ms
`define TMR_FAST_MS        5
`define TMR_SLOW_MS        100
`define WAKE_DELAY_MS      50

// stop operand value that is accepted
`define STOP_OPERAND       4'h0

// register indices; byte address is four times the index
`define IDX_STATUS         8'h07
`define IDX_TIMER_FLAG     8'h17
`define IDX_CTRL           8'h20
`define IDX_ADC_SEL        8'h21
`define IDX_SER_DIR        8'h22
`define IDX_PORT_DIR       8'h23
`define IDX_OUT_PORT       8'h24
`define IDX_STATE          8'h30

// control register fields
`define CTRL_SERIAL        0
`define CTRL_DISPLAY       1
`define CTRL_ADC           2
`define CTRL_FAST          3

// reset and stop-init values
`define CTRL_INIT          4'h0
`define ADC_SEL_INIT       2'h0
`define SER_DIR_INIT       4'h0
`define PORT_DIR_RST       4'h0
`define OUT_PORT_RST       4'h0

`endif

// *** shared/clock_stop_standby_pkg.sv ***
package clock_stop_standby_pkg;

    // run: executing; halt: pc frozen; stop: oscillator off;
    // wake: oscillator back, waiting for the timer carry to reset
    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_STOP,
        ST_WAKE
    } standby_state_t;

endpackage

// *** design/standby_pin_filter.sv ***
`timescale 1ns/100ps
`include "clock_stop_standby_map.svh"

module standby_pin_filter (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);

    localparam logic [11:0] DEB_LAST = 12'(`DEB_CYC - 1);

    logic        sync1_q;
    logic        sync2_q;
    logic        level_q;
    logic        level_d;
    logic        rise_q;
    logic        rise_d;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;

    // level changes only after the raw pin has differed for the whole filter time
    always_comb begin
        level_d = level_q;
        rise_d  = 1'b0;
        cnt_d   = 12'h000;
        if (sync2_q != level_q) begin
            if (cnt_q == DEB_LAST) begin
                level_d = sync2_q;
                rise_d  = sync2_q;
            end else begin
                cnt_d = cnt_q + 12'h001;
            end
        end
    end

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            cnt_q   <= 12'h000;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            level_q <= level_d;
            rise_q  <= rise_d;
            cnt_q   <= cnt_d;
        end
    end

    assign level = level_q;
    assign rise  = rise_q;

endmodule

// *** design/clock_stop_standby_control.sv ***
// How it works
// - stop honoured only while standby pin low
// - stop halts oscillator, cpu and peripherals
// - power failure detector off during stop
// - exit stop by pin rise or power-on
// - power-on exit re-enables power failure detector
// - stop initialises control register, halt keeps
// - halt freezes program counter at halt
// - stop zeroes pc, inits system register
// - halt keeps peripherals running as programmed, except serial and display
// - stop aborts serial, serial pins input
// - stop forces bidirectional port pins input
// - stop keeps dedicated outputs driving held values
// - pull-down off on selected converter pin
// - display holds in halt-high, stops when low
// - stop disables display, pulls xin low, drives xout high
// - nop stop with pin high resets at carry
// - standby level readable at index 07h bit 0
// - standby pulses shorter than filter time ignored
// - timer carry set every 5 or 100 ms
// - after stop, reset lands 50 ms after rise
`timescale 1ns/100ps
`include "clock_stop_standby_map.svh"

module clock_stop_standby_control #(
    parameter int TMR_FAST_CYC = `TMR_FAST_MS * `CLK_KHZ,
    parameter int TMR_SLOW_CYC = `TMR_SLOW_MS * `CLK_KHZ,
    parameter int WAKE_CYC     = `WAKE_DELAY_MS * `CLK_KHZ
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        standby_en_pin,
    input  wire logic        power_low_pin,
    input  wire logic        instr_valid,
    input  wire logic        instr_is_stop,
    input  wire logic        instr_is_halt,
    input  wire logic [3:0]  instr_operand,
    input  wire logic        halt_release,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             instr_done,
    output logic             instr_nop,
    output logic             osc_enable,
    output logic             cpu_run,
    output logic             pc_hold,
    output logic             pc_load_zero,
    output logic             sysreg_init,
    output logic             standby_reset,
    output logic             pfd_enable,
    output logic             timer_carry,
    output logic             periph_run,
    output logic             serial_enable,
    output logic             serial_abort,
    output logic [3:0]       serial_port_a_oe,
    output logic [3:0]       bidir_port_oe,
    output logic [3:0]       out_port_val,
    output logic [3:0]       key_input_port_pulldown,
    output logic             on_screen_display_controller_en,
    output logic             on_screen_display_controller_freeze,
    output logic             xin_pulldown,
    output logic             xout_drive_high
);

    localparam logic [19:0] FAST_LAST = 20'(TMR_FAST_CYC - 1);
    localparam logic [19:0] SLOW_LAST = 20'(TMR_SLOW_CYC - 1);
    localparam logic [19:0] WAKE_LOAD = 20'(TMR_SLOW_CYC - WAKE_CYC);

    clock_stop_standby_pkg::standby_state_t state_q;
    clock_stop_standby_pkg::standby_state_t state_d;

    logic        stby_level;
    logic        stby_rise;
    logic        pwr_sync1_q;
    logic        pwr_low_q;
    logic        pwr_low_old_q;
    logic        pwr_fall;
    logic [19:0] tcount_q;
    logic [19:0] tcount_d;
    logic [19:0] tc_last;
    logic        carry;
    logic        armed_q;
    logic        armed_d;
    logic        pfd_q;
    logic        pfd_d;
    logic        stop_enter;
    logic        stop_nop;
    logic        halt_enter;
    logic        ce_fire;
    logic        ctrl_init;
    logic        done_q;
    logic        nop_q;
    logic        pcz_q;
    logic        pcz_d;
    logic        sri_q;
    logic        reset_q;
    logic        carry_q;
    logic [3:0]  ctrl_q;
    logic [3:0]  ctrl_d;
    logic [1:0]  adc_sel_q;
    logic [1:0]  adc_sel_d;
    logic [3:0]  ser_dir_q;
    logic [3:0]  ser_dir_d;
    logic [3:0]  port_dir_q;
    logic [3:0]  port_dir_d;
    logic [3:0]  out_port_q;
    logic [3:0]  out_port_d;
    logic        tflag_q;
    logic        tflag_d;
    logic        abort_q;
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0]  idx;
    logic        wr_take;
    logic [3:0]  pull_q;
    logic [3:0]  pull_d;

    // standby enable pin: synchronised and noise filtered
    standby_pin_filter u_filter (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pin_in  (standby_en_pin),
        .level   (stby_level),
        .rise    (stby_rise)
    );

    // power-low detector level crosses in through two flops
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pwr_sync1_q   <= 1'b0;
            pwr_low_q     <= 1'b0;
            pwr_low_old_q <= 1'b0;
        end else begin
            pwr_sync1_q   <= power_low_pin;
            pwr_low_q     <= pwr_sync1_q;
            pwr_low_old_q <= pwr_low_q;
        end
    end

    assign pwr_fall = pwr_low_old_q & ~pwr_low_q;

    // instruction decode; level taken in the instruction's own cycle
    assign stop_enter = instr_valid & (state_q == clock_stop_standby_pkg::ST_RUN)
                      & instr_is_stop & (instr_operand == `STOP_OPERAND)
                      & ~stby_level & ~pwr_low_q;
    assign stop_nop   = instr_valid & (state_q == clock_stop_standby_pkg::ST_RUN)
                      & instr_is_stop & ~stop_enter;
    assign halt_enter = instr_valid & (state_q == clock_stop_standby_pkg::ST_RUN)
                      & instr_is_halt & ~instr_is_stop;

    // timer carry: runs in every state but stop; period from the fast bit
    assign tc_last = ctrl_q[`CTRL_FAST] ? FAST_LAST : SLOW_LAST;
    assign carry   = (state_q != clock_stop_standby_pkg::ST_STOP) & ~pwr_low_q
                   & (tcount_q == tc_last);
    assign ce_fire = carry & armed_q & stby_level;
    assign ctrl_init = stop_enter | pwr_low_q;

    // sequencer next state, timer and pulses
    always_comb begin
        state_d  = state_q;
        tcount_d = tcount_q;
        armed_d  = armed_q;
        pfd_d    = pfd_q;
        pcz_d    = 1'b0;
        if ((state_q != clock_stop_standby_pkg::ST_STOP) && !pwr_low_q) begin
            tcount_d = carry ? 20'h00000 : tcount_q + 20'h00001;
        end
        // a rise of the pin, or a nop stop with the pin high, arms the reset
        if (stby_rise || (stop_nop && stby_level)) begin
            armed_d = 1'b1;
        end else if (!stby_level) begin
            armed_d = 1'b0;
        end
        case (state_q)
            clock_stop_standby_pkg::ST_RUN: begin
                if (stop_enter) begin
                    state_d = clock_stop_standby_pkg::ST_STOP;
                    pfd_d   = 1'b0;
                    pcz_d   = 1'b1;
                end else if (halt_enter) begin
                    state_d = clock_stop_standby_pkg::ST_HALT;
                end
            end
            clock_stop_standby_pkg::ST_HALT: begin
                if (halt_release) begin
                    state_d = clock_stop_standby_pkg::ST_RUN;
                end
            end
            clock_stop_standby_pkg::ST_STOP: begin
                if (stby_rise && !pwr_low_q) begin
                    // restart so the 100 ms carry lands half a period later
                    state_d  = clock_stop_standby_pkg::ST_WAKE;
                    tcount_d = WAKE_LOAD;
                end
            end
            clock_stop_standby_pkg::ST_WAKE: begin
                state_d = clock_stop_standby_pkg::ST_WAKE;
            end
            default: begin
                state_d = clock_stop_standby_pkg::ST_RUN;
            end
        endcase
        if (ce_fire) begin
            state_d = clock_stop_standby_pkg::ST_RUN;
            armed_d = 1'b0;
            pcz_d   = 1'b1;
        end
        // supply below the clear level stops the clock like a stop does
        if (pwr_low_q) begin
            state_d  = clock_stop_standby_pkg::ST_STOP;
            tcount_d = 20'h00000;
            armed_d  = 1'b0;
        end else if (pwr_fall) begin
            state_d = clock_stop_standby_pkg::ST_RUN;
            pfd_d   = 1'b1;
            pcz_d   = 1'b1;
        end
    end

    // sequencer registers and the outputs derived from the next state
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q   <= clock_stop_standby_pkg::ST_RUN;
            tcount_q  <= 20'h00000;
            armed_q   <= 1'b0;
            pfd_q     <= 1'b1;
            pcz_q     <= 1'b0;
            sri_q     <= 1'b0;
            reset_q   <= 1'b0;
            carry_q   <= 1'b0;
            done_q    <= 1'b0;
            nop_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            tcount_q  <= tcount_d;
            armed_q   <= armed_d;
            pfd_q     <= pfd_d;
            pcz_q     <= pcz_d;
            sri_q     <= pcz_d;
            reset_q   <= ce_fire;
            carry_q   <= carry;
            done_q    <= stop_nop | stop_enter | halt_enter;
            nop_q     <= stop_nop;
        end
    end

    // register bus: one wait cycle, then a single-cycle answer
    assign idx     = avs_address[9:2];
    assign wr_take = avs_write & ~wait_q;

    always_comb begin
        wait_d     = ~((avs_read | avs_write) & wait_q);
        rdata_d    = rdata_q;
        ctrl_d     = ctrl_q;
        adc_sel_d  = adc_sel_q;
        ser_dir_d  = ser_dir_q;
        port_dir_d = port_dir_q;
        out_port_d = out_port_q;
        tflag_d    = tflag_q;
        if (avs_read && wait_q) begin
            rdata_d = 32'h00000000;
            if (idx == `IDX_STATUS) begin
                rdata_d[0] = stby_level;
            end else if (idx == `IDX_TIMER_FLAG) begin
                rdata_d[0] = tflag_q;
            end else if (idx == `IDX_CTRL) begin
                rdata_d[3:0] = ctrl_q;
            end else if (idx == `IDX_ADC_SEL) begin
                rdata_d[1:0] = adc_sel_q;
            end else if (idx == `IDX_SER_DIR) begin
                rdata_d[3:0] = ser_dir_q;
            end else if (idx == `IDX_PORT_DIR) begin
                rdata_d[3:0] = port_dir_q;
            end else if (idx == `IDX_OUT_PORT) begin
                rdata_d[3:0] = out_port_q;
            end else if (idx == `IDX_STATE) begin
                rdata_d[1:0] = state_q;
                rdata_d[2]   = pfd_q;
                rdata_d[3]   = armed_q;
            end
        end
        if (wr_take) begin
            if (idx == `IDX_TIMER_FLAG) begin
                tflag_d = tflag_q & ~avs_writedata[0];
            end else if (idx == `IDX_CTRL) begin
                ctrl_d = avs_writedata[3:0];
            end else if (idx == `IDX_ADC_SEL) begin
                adc_sel_d = avs_writedata[1:0];
            end else if (idx == `IDX_SER_DIR) begin
                ser_dir_d = avs_writedata[3:0];
            end else if (idx == `IDX_PORT_DIR) begin
                port_dir_d = avs_writedata[3:0];
            end else if (idx == `IDX_OUT_PORT
                         && state_q != clock_stop_standby_pkg::ST_STOP) begin
                out_port_d = avs_writedata[3:0];
            end
        end
        // carry set wins over a clear in the same cycle
        if (carry) begin
            tflag_d = 1'b1;
        end
        // stop re-initialises control state; port and output data are kept
        if (ctrl_init) begin
            ctrl_d    = `CTRL_INIT;
            adc_sel_d = `ADC_SEL_INIT;
            ser_dir_d = `SER_DIR_INIT;
        end
    end

    // pull-down stays on except on the pin routed to the converter
    for (genvar i = 0; i < 4; i++) begin : g_pull
        assign pull_d[i] = ~(ctrl_d[`CTRL_ADC] & (adc_sel_d == 2'(i)));
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wait_q     <= 1'b1;
            rdata_q    <= 32'h00000000;
            ctrl_q     <= `CTRL_INIT;
            adc_sel_q  <= `ADC_SEL_INIT;
            ser_dir_q  <= `SER_DIR_INIT;
            port_dir_q <= `PORT_DIR_RST;
            out_port_q <= `OUT_PORT_RST;
            tflag_q    <= 1'b0;
            abort_q    <= 1'b0;
            pull_q     <= 4'hf;
        end else begin
            wait_q     <= wait_d;
            rdata_q    <= rdata_d;
            ctrl_q     <= ctrl_d;
            adc_sel_q  <= adc_sel_d;
            ser_dir_q  <= ser_dir_d;
            port_dir_q <= port_dir_d;
            out_port_q <= out_port_d;
            tflag_q    <= tflag_d;
            abort_q    <= ctrl_init & ctrl_q[`CTRL_SERIAL];
            pull_q     <= pull_d;
        end
    end

    // pin and block controls are registered from the next state and change on the same edge as the state
    logic       osc_q;
    logic       run_q;
    logic       periph_q;
    logic       ser_en_q;
    logic [3:0] ser_oe_q;
    logic [3:0] bidir_q;
    logic       disp_en_q;
    logic       disp_frz_q;
    logic       stopped_q;
    logic       in_stop_d;
    logic       in_halt_d;

    assign in_stop_d = (state_d == clock_stop_standby_pkg::ST_STOP);
    assign in_halt_d = (state_d == clock_stop_standby_pkg::ST_HALT);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            osc_q      <= 1'b1;
            run_q      <= 1'b1;
            periph_q   <= 1'b1;
            ser_en_q   <= 1'b0;
            ser_oe_q   <= 4'h0;
            bidir_q    <= 4'h0;
            disp_en_q  <= 1'b0;
            disp_frz_q <= 1'b0;
            stopped_q  <= 1'b0;
        end else begin
            osc_q      <= ~in_stop_d;
            run_q      <= (state_d == clock_stop_standby_pkg::ST_RUN);
            periph_q   <= ~in_stop_d;
            ser_en_q   <= ctrl_d[`CTRL_SERIAL] & ~in_stop_d & ~in_halt_d;
            ser_oe_q   <= in_stop_d ? 4'h0 : ser_dir_d;
            bidir_q    <= in_stop_d ? 4'h0 : port_dir_d;
            // display: frozen in halt with pin high, off with pin low
            disp_en_q  <= ctrl_d[`CTRL_DISPLAY] & ~in_stop_d
                        & ~(in_halt_d & ~stby_level);
            disp_frz_q <= in_halt_d & stby_level;
            stopped_q  <= in_stop_d;
        end
    end

    assign avs_readdata                        = rdata_q;
    assign avs_waitrequest                     = wait_q;
    assign instr_done                          = done_q;
    assign instr_nop                           = nop_q;
    assign osc_enable                          = osc_q;
    assign cpu_run                             = run_q;
    assign pc_hold                             = ~run_q;
    assign pc_load_zero                        = pcz_q;
    assign sysreg_init                         = sri_q;
    assign standby_reset                       = reset_q;
    assign pfd_enable                          = pfd_q;
    assign timer_carry                         = carry_q;
    assign periph_run                          = periph_q;
    assign serial_enable                       = ser_en_q;
    assign serial_abort                        = abort_q;
    assign serial_port_a_oe                    = ser_oe_q;
    assign bidir_port_oe                       = bidir_q;
    assign out_port_val                        = out_port_q;
    assign key_input_port_pulldown             = pull_q;
    assign on_screen_display_controller_en     = disp_en_q;
    assign on_screen_display_controller_freeze = disp_frz_q;
    assign xin_pulldown                        = stopped_q;
    assign xout_drive_high                     = stopped_q;

endmodule

// *** tb/clock_stop_standby_properties.sv ***
`timescale 1ns/100ps
module clock_stop_standby_properties (
    input logic       sys_clk,
    input logic       rstn,
    input logic       instr_valid,
    input logic       instr_is_stop,
    input logic       instr_is_halt,
    input logic       instr_done,
    input logic       instr_nop,
    input logic       osc_enable,
    input logic       cpu_run,
    input logic       pc_hold,
    input logic       pc_load_zero,
    input logic       sysreg_init,
    input logic       standby_reset,
    input logic       pfd_enable,
    input logic       periph_run,
    input logic [3:0] serial_port_a_oe,
    input logic [3:0] bidir_port_oe,
    input logic [3:0] key_input_port_pulldown,
    input logic       on_screen_display_controller_en,
    input logic       on_screen_display_controller_freeze,
    input logic       xin_pulldown,
    input logic       xout_drive_high
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // a taken stop or halt is answered exactly one cycle later
    chk_done_one_cycle: assert property (instr_valid && cpu_run &&
        (instr_is_stop || instr_is_halt) |=> instr_done) else $error("late done");
    // stop entry clears pc, inits sysreg and parks the detector
    chk_stop_entry: assert property (instr_done && !osc_enable |->
        !pfd_enable && pc_load_zero && sysreg_init && !cpu_run) else $error("bad stop entry");
    chk_nop_runs_on: assert property (instr_nop |->
        instr_done && osc_enable && cpu_run) else $error("nop stopped cpu");
    // no bidirectional or serial port pin may drive with the oscillator off
    chk_stop_pins_in: assert property (!osc_enable |->
        bidir_port_oe == 4'h0 && serial_port_a_oe == 4'h0) else $error("pin drives in stop");
    chk_stop_xtal: assert property (xin_pulldown == !osc_enable &&
        xout_drive_high == !osc_enable) else $error("xtal pins wrong");
    chk_stop_display: assert property (!osc_enable |->
        !on_screen_display_controller_en) else $error("display on in stop");
    chk_halt_freeze: assert property (on_screen_display_controller_freeze |->
        pc_hold && osc_enable && periph_run) else $error("freeze outside halt");
    // only one converter pin may lose its pull-down
    chk_pulldown_one: assert property ($countones(~key_input_port_pulldown) <= 1)
        else $error("two pull-downs off");
    chk_ce_reset_pc: assert property (standby_reset |->
        pc_load_zero && sysreg_init) else $error("reset without pc load");
endmodule

// *** tb/standby_source.sv ***
`timescale 1ns/100ps
// firmware side sources: standby pin and supply monitor level
module standby_source (
    input  wire logic sys_clk,
    output logic      standby_en_pin,
    output logic      power_low_pin
);
    // both start inactive so the first stop sees a low pin
    initial begin
        standby_en_pin = 1'h0;
        power_low_pin  = 1'h0;
    end
    // set_pin callers hold a level well past the noise filter, else it is dropped; the power level is not filtered
    task automatic set_pin(input logic v);
        @(posedge sys_clk);
        standby_en_pin <= v;
    endtask
    task automatic set_power(input logic v);
        @(posedge sys_clk);
        power_low_pin <= v;
    endtask
endmodule

// *** tb/clock_stop_standby_control_tb.sv ***
`timescale 1ns/100ps
module clock_stop_standby_control_tb;
    logic        sys_clk = 1'h0, rstn = 1'h0, standby_en_pin, power_low_pin;
    logic        instr_valid = 1'h0, instr_is_stop = 1'h0, instr_is_halt = 1'h0;
    logic        halt_release = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic [3:0]  instr_operand = 4'h0;
    logic [9:0]  avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
    logic        avs_waitrequest, instr_done, instr_nop, osc_enable, cpu_run, pc_hold;
    logic        pc_load_zero, sysreg_init, standby_reset, pfd_enable, timer_carry;
    logic        periph_run, serial_enable, serial_abort, xin_pulldown, xout_drive_high;
    logic        on_screen_display_controller_en, on_screen_display_controller_freeze;
    logic [3:0]  serial_port_a_oe, bidir_port_oe, out_port_val, key_input_port_pulldown;
    int          error_cnt = 0, n_compared = 0, cnt;

    standby_source i_standby_source (.sys_clk, .standby_en_pin, .power_low_pin);
    // short timer counts keep the wake wait to tens of cycles
    clock_stop_standby_control #(.TMR_FAST_CYC(50), .TMR_SLOW_CYC(100), .WAKE_CYC(50))
    i_clock_stop_standby_control (.sys_clk, .rstn, .standby_en_pin, .power_low_pin,
        .instr_valid, .instr_is_stop, .instr_is_halt, .instr_operand, .halt_release,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .instr_done, .instr_nop, .osc_enable, .cpu_run, .pc_hold,
        .pc_load_zero, .sysreg_init, .standby_reset, .pfd_enable, .timer_carry,
        .periph_run, .serial_enable, .serial_abort, .serial_port_a_oe, .bidir_port_oe,
        .out_port_val, .key_input_port_pulldown, .on_screen_display_controller_en,
        .on_screen_display_controller_freeze, .xin_pulldown, .xout_drive_high);

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= {idx, 2'h0};
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
        rdata = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'h0, idx, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // one instruction; returns just after the answer lands
    task automatic ins(input logic s, input logic h, input logic [3:0] op);
        @(posedge sys_clk);
        instr_valid   <= 1'h1;
        instr_is_stop <= s;
        instr_is_halt <= h;
        instr_operand <= op;
        @(posedge sys_clk);
        instr_valid <= 1'h0;
        #1;
    endtask
    task automatic release_halt();
        @(posedge sys_clk);
        halt_release <= 1'h1;
        @(posedge sys_clk);
        halt_release <= 1'h0;
        tick(2);
    endtask
    // counts cycles until the standby reset pulse, bounded by lim
    task automatic wait_ce(input int lim);
        cnt = 0;
        while (standby_reset !== 1'h1 && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'h1;
        rdc(8'h10, 32'h0);
        rdc(8'h07, 32'h0);
        bus(1'h1, 8'h20, 32'h7);
        bus(1'h1, 8'h21, 32'h2);
        bus(1'h1, 8'h22, 32'hf);
        bus(1'h1, 8'h23, 32'hf);
        bus(1'h1, 8'h24, 32'h5);
        tick(2);
        chk({serial_enable, key_input_port_pulldown}, 32'h1b);
        // halt with the pin low keeps ctrl, stops the display
        ins(1'h0, 1'h1, 4'h0);
        chk({cpu_run, pc_hold, on_screen_display_controller_en, periph_run}, 32'h5);
        rdc(8'h20, 32'h7);
        release_halt();
        // a stop with any operand but zero must fall through as a nop
        ins(1'h1, 1'h0, 4'h3);
        chk({instr_done, instr_nop, osc_enable, cpu_run}, 32'hf);
        ins(1'h1, 1'h0, 4'h0);
        chk({instr_done, instr_nop, osc_enable, pfd_enable, serial_abort, xin_pulldown}, 32'h23);
        chk({bidir_port_oe, serial_port_a_oe, out_port_val}, 32'h005);
        // wake by pin rise: filter time plus the 100 ms half period
        i_standby_source.set_pin(1'h1);
        wait_ce(2500);
        chk(32'(cnt >= 1925 && cnt <= 1945), 32'h1);
        tick(2);
        rdc(8'h20, 32'h0);
        rdc(8'h07, 32'h1);
        chk(key_input_port_pulldown, 32'hf);
        ins(1'h0, 1'h1, 4'h0);
        chk({on_screen_display_controller_freeze, pc_hold}, 32'h3);
        release_halt();
        // stop with the pin high is a nop, reset follows the 5 ms carry
        bus(1'h1, 8'h20, 32'h8);
        ins(1'h1, 1'h0, 4'h0);
        chk({instr_done, instr_nop, osc_enable}, 32'h7);
        wait_ce(60);
        chk(32'(cnt <= 52), 32'h1);
        i_standby_source.set_power(1'h1);
        tick(5);
        chk({osc_enable, cpu_run}, 32'h0);
        i_standby_source.set_power(1'h0);
        tick(5);
        chk({pfd_enable, cpu_run}, 32'h3);
        give_verdict();
    end

    // a hang counts as a mismatch; the tests need under 5000 cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        give_verdict();
    end
endmodule

bind clock_stop_standby_control clock_stop_standby_properties i_clock_stop_standby_properties (
    .sys_clk, .rstn, .instr_valid, .instr_is_stop, .instr_is_halt, .instr_done, .instr_nop,
    .osc_enable, .cpu_run, .pc_hold, .pc_load_zero, .sysreg_init, .standby_reset,
    .pfd_enable, .periph_run, .serial_port_a_oe, .bidir_port_oe, .key_input_port_pulldown,
    .on_screen_display_controller_en, .on_screen_display_controller_freeze,
    .xin_pulldown, .xout_drive_high);
